// *** hw/icco_params.svh ***
// icco_params.svh: offsets, field positions, reset values and timing of the io cell block
`ifndef ICCO_PARAMS_SVH
`define ICCO_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ICCO_CFG_ADDR 12'h000
`define ICCO_OCTL_ADDR 12'h004
`define ICCO_STAT_ADDR 12'h008

// ****************************************************************
// field positions
// ****************************************************************
`define ICCO_CFG_W 11
`define ICCO_CFG_LO_W 8
`define ICCO_OCTL_W 3
`define ICCO_OCTL_GSR_BIT 3
`define ICCO_STAT_W 6

// ****************************************************************
// reset values
// ****************************************************************
// output registered, clear on set/reset, no inversions, no delay
`define ICCO_CFG_RST 11'h004
// clock enable reads high and float low, as if left unconnected
`define ICCO_OCTL_RST 3'h2

// ****************************************************************
// input delay codes and timing
// ****************************************************************
`define ICCO_DLY_NONE 2'h0
`define ICCO_DLY_MEDIUM 2'h1
`define ICCO_DLY_LONG 2'h2
`define ICCO_CLK_PERIOD_NS 10

`endif

// *** hw/icco_pkg.sv ***
// icco_pkg.sv: types of the io cell capture and output block
package icco_pkg;

  // configuration word, msb first as laid out in the config register
  typedef struct packed {
    logic fast_en;
    logic in_latch_mode;
    logic cap_clk_inv;
    logic in_clk_inv;
    logic [1:0] delay_sel;
    logic delay_manual;
    logic out_inv;
    logic out_reg;
    logic float_inv;
    logic sr_set;
  } icco_cfg_t;

  // output control word
  typedef struct packed {
    logic flt;
    logic ce;
    logic data;
  } icco_octl_t;

  // whole state of the cell
  typedef struct packed {
    icco_cfg_t cfg;
    icco_octl_t octl;
    logic pad_s1;
    logic pad_s2;
    logic oclk_s1;
    logic oclk_s2;
    logic oclk_d;
    logic iclk_s1;
    logic iclk_s2;
    logic iclk_d;
    logic gf_s1;
    logic gf_s2;
    logic ex_s1;
    logic ex_s2;
    logic [1:0] prime; // cycles since reset, saturates at three
    logic [1:0] dly;
    logic cap_q;
    logic in_q;
    logic out_q;
    logic pad_q;
    logic oe_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } icco_state_t;

endpackage

// *** hw/icco_cell.sv ***
// icco_cell.sv: one programmable io cell with fast capture input and configurable output
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "icco_params.svh"

// Operation
// - fast capture latch runs on the output clock, not the input clock
// - second input stage retimes fast capture data into the internal domain
// - latch-then-flop: capture latch transparent low, then rising-edge flop
// - latch-then-latch: capture latch transparent low, then latch transparent high
// - each input storage clock may be inverted inside the cell
// - fast capture selects medium input delay by default, others still selectable
// - output optionally inverted, then driven directly or through an edge flop
// - high float control puts the driver in high impedance regardless of all else
// - output and float polarities are configured independently
// - global set/reset loads the configured set/reset value, power-up clears the output flop to 0
// - output flop captures on rising edge with enable high, else holds
// - clock enable left alone behaves as high
// - float control left alone behaves as low, driver enabled
// - only power-up reset (to 0) and the global set/reset net (to sr_set) set or clear the output flop
// - global float forces high impedance unless boundary scan runs extest
module icco_cell (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_out,
  input wire logic out_clk_in,
  input wire logic in_clk_in,
  input wire logic global_float_in,
  input wire logic extest_in,
  output logic in_data_out
);

  // ****************************************************************
  // state and derived terms
  // ****************************************************************
  icco_pkg::icco_state_t r;
  icco_pkg::icco_state_t n;

  logic cap_clk_eff;
  logic in_clk_eff;
  logic in_clk_prev;
  logic in_clk_rise;
  logic out_clk_rise;
  logic sync_primed;
  logic [1:0] eff_sel;
  logic dly_src;
  logic stage2_src;
  logic out_val;
  logic float_req;
  logic force_float;
  logic apb_take;
  logic wr_en;
  logic hit_cfg;
  logic hit_octl;
  logic hit_stat;
  logic gsr_pulse;
  logic [31:0] rd_word;

  // clock views seen by each storage element, inversion absorbed here
  assign cap_clk_eff = r.oclk_s2 ^ r.cfg.cap_clk_inv;
  assign in_clk_eff = r.iclk_s2 ^ r.cfg.in_clk_inv;
  assign in_clk_prev = r.iclk_d ^ r.cfg.in_clk_inv;
  // edges count only once the synchronisers hold real pin levels; a clock pin
  // sitting high through reset would otherwise look like a rise two cycles on
  assign sync_primed = (r.prime == 2'h3);
  assign in_clk_rise = in_clk_eff & ~in_clk_prev & sync_primed;
  assign out_clk_rise = r.oclk_s2 & ~r.oclk_d & sync_primed;

  // delay choice: fast capture forces medium unless software takes over
  always_comb begin
    if (r.cfg.fast_en && !r.cfg.delay_manual) begin
      eff_sel = `ICCO_DLY_MEDIUM;
    end else begin
      eff_sel = r.cfg.delay_sel;
    end
  end

  // two-tap delay on the synchronised pad sample
  always_comb begin
    case (eff_sel)
      `ICCO_DLY_NONE: dly_src = r.pad_s2;
      `ICCO_DLY_MEDIUM: dly_src = r.dly[0];
      default: dly_src = r.dly[1];
    endcase
  end

  // second stage reads the capture latch only when fast capture is on
  assign stage2_src = r.cfg.fast_en ? r.cap_q : dly_src;

  // polarity of value and float set independently
  assign out_val = r.octl.data ^ r.cfg.out_inv;
  assign float_req = r.octl.flt ^ r.cfg.float_inv;
  assign force_float = r.gf_s2 & ~r.ex_s2;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // write lands only on the edge that sees pready high
  assign apb_take = psel_in & penable_in & r.pready;
  assign wr_en = apb_take & pwrite_in;

  always_comb begin
    hit_cfg = 1'b0;
    hit_octl = 1'b0;
    hit_stat = 1'b0;
    if (paddr_in == `ICCO_CFG_ADDR) begin
      hit_cfg = 1'b1;
    end else if (paddr_in == `ICCO_OCTL_ADDR) begin
      hit_octl = 1'b1;
    end else if (paddr_in == `ICCO_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  // software pulse of the global set/reset net
  assign gsr_pulse = wr_en & hit_octl & pstrb_in[0] & pwdata_in[`ICCO_OCTL_GSR_BIT];

  // read mux, unmapped reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cfg) begin
      rd_word[`ICCO_CFG_W-1:0] = r.cfg;
    end else if (hit_octl) begin
      rd_word[`ICCO_OCTL_W-1:0] = r.octl;
    end else if (hit_stat) begin
      rd_word[`ICCO_STAT_W-1:0] = {r.pad_s2, r.oe_q, r.pad_q, r.out_q, r.cap_q, r.in_q};
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    // two-flop synchronisers, first stage read by the second only
    n.pad_s1 = pad_in;
    n.pad_s2 = r.pad_s1;
    n.oclk_s1 = out_clk_in;
    n.oclk_s2 = r.oclk_s1;
    n.oclk_d = r.oclk_s2;
    n.iclk_s1 = in_clk_in;
    n.iclk_s2 = r.iclk_s1;
    n.iclk_d = r.iclk_s2;
    n.gf_s1 = global_float_in;
    n.gf_s2 = r.gf_s1;
    n.ex_s1 = extest_in;
    n.ex_s2 = r.ex_s1;
    n.dly = {r.dly[0], r.pad_s2};

    // settle count after reset; a real edge in these cycles is lost
    if (r.prime != 2'h3) begin
      n.prime = r.prime + 2'h1;
    end

    // fast capture latch, transparent while its clock is low
    if (!cap_clk_eff) begin
      n.cap_q = dly_src;
    end

    // second stage: flop on rising edge, or latch transparent high
    if (r.cfg.in_latch_mode) begin
      if (in_clk_eff) begin
        n.in_q = stage2_src;
      end
    end else if (in_clk_rise) begin
      n.in_q = stage2_src;
    end

    // output flop: global set/reset wins over any clock edge
    if (gsr_pulse) begin
      n.out_q = r.cfg.sr_set;
    end else if (out_clk_rise && r.octl.ce) begin
      n.out_q = out_val;
    end

    // pad drive; the direct path still costs one register stage
    n.pad_q = r.cfg.out_reg ? r.out_q : out_val;
    n.oe_q = ~(float_req | force_float);

    // register writes, byte lanes honoured
    if (wr_en && hit_cfg) begin
      if (pstrb_in[0]) begin
        n.cfg[`ICCO_CFG_LO_W-1:0] = pwdata_in[`ICCO_CFG_LO_W-1:0];
      end
      if (pstrb_in[1]) begin
        n.cfg[`ICCO_CFG_W-1:`ICCO_CFG_LO_W] = pwdata_in[`ICCO_CFG_W-1:`ICCO_CFG_LO_W];
      end
    end else if (wr_en && hit_octl && pstrb_in[0]) begin
      n.octl = pwdata_in[`ICCO_OCTL_W-1:0];
    end

    // one wait state keeps every bus output on a flop
    if (apb_take) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
    end else if (psel_in && penable_in) begin
      n.pready = 1'b1;
      n.pslverr = ~(hit_cfg | hit_octl | hit_stat);
      n.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // power-up clears the output flop, matching the default clear value
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.cfg <= `ICCO_CFG_RST;
      r.octl <= `ICCO_OCTL_RST;
      r.oe_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign pready_out = r.pready;
  assign prdata_out = r.prdata;
  assign pslverr_out = r.pslverr;
  assign pad_out = r.pad_q;
  assign pad_oe_out = r.oe_q;
  assign in_data_out = r.in_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // bus steps, used by the answer-wait check
  sequence s_setup;
    psel_in && !penable_in;
  endsequence

  sequence s_access;
    psel_in && penable_in;
  endsequence

  // input stage steps; each names one storage element taking new data
  sequence s_cap_open;
    !cap_clk_eff;
  endsequence

  sequence s_flop_edge;
    !r.cfg.in_latch_mode && in_clk_rise;
  endsequence

  sequence s_latch_open;
    r.cfg.in_latch_mode && in_clk_eff;
  endsequence

  // bus handshake: answer one cycle after access, then straight back to idle
  a_apb_answer_wait: assert property (s_setup ##1 s_access |=> pready_out)
    else $error("apb answer not one cycle after access start");

  // a second ready cycle would let the master take a stale answer twice
  a_apb_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held for more than one cycle");

  // no selected transfer, no answer and no error
  a_apb_idle_quiet: assert property (!psel_in |=> !pready_out && !pslverr_out)
    else $error("bus answer without a selected transfer");

  // pad drive and float, each one register stage behind its cause
  a_global_float_hiz: assert property (force_float |=> !pad_oe_out)
    else $error("global float did not float the pad");

  a_float_ctl_hiz: assert property (float_req |=> !pad_oe_out)
    else $error("float control did not float the pad");

  // with nothing asking for float the driver must come back
  a_driver_enabled: assert property (!float_req && !force_float |=> pad_oe_out)
    else $error("driver off with no float request");

  // direct path still passes one flop, so the pad follows one cycle late
  // and a data change one cycle on is not an error
  a_direct_path: assert property (!r.cfg.out_reg
    |=> pad_out == $past(out_val))
    else $error("direct output path wrong");

  a_registered_path: assert property (r.cfg.out_reg
    |=> pad_out == $past(r.out_q))
    else $error("registered output path wrong");

  // output flop: load on enabled edge, hold otherwise, set/reset wins
  a_out_flop_load: assert property (!gsr_pulse && out_clk_rise && r.octl.ce
    |=> r.out_q == $past(out_val))
    else $error("output flop missed its edge");

  a_out_flop_hold: assert property (!gsr_pulse && !(out_clk_rise && r.octl.ce)
    |=> $stable(r.out_q))
    else $error("output flop changed without enabled edge");

  a_gsr_loads_sr: assert property (gsr_pulse |=> r.out_q == $past(r.cfg.sr_set))
    else $error("set/reset value not loaded");

  // input path: capture latch, delay choice, second stage
  a_cap_hold_high: assert property (cap_clk_eff |=> $stable(r.cap_q))
    else $error("capture latch moved while closed");

  a_cap_open_low: assert property (s_cap_open
    |=> r.cap_q == $past(dly_src))
    else $error("capture latch not transparent low");

  a_medium_default: assert property (r.cfg.fast_en && !r.cfg.delay_manual
    |-> eff_sel == `ICCO_DLY_MEDIUM)
    else $error("fast capture without medium delay");

  a_second_latch: assert property (s_latch_open
    |=> r.in_q == $past(stage2_src))
    else $error("second latch not transparent high");

  // a closed second latch must keep its value through any data change
  a_latch_closed: assert property (r.cfg.in_latch_mode && !in_clk_eff
    |=> $stable(r.in_q))
    else $error("second latch moved while closed");

  a_second_flop: assert property (!r.cfg.in_latch_mode && !in_clk_rise
    |=> $stable(r.in_q))
    else $error("input flop moved without rising edge");

  a_flop_edge_load: assert property (s_flop_edge
    |=> r.in_q == $past(stage2_src))
    else $error("input flop missed its rising edge");

  // with fast capture on, the second stage must retime the latched value,
  // not the raw pad sample
  a_fast_retime: assert property (r.cfg.fast_en ##0 s_flop_edge
    |=> r.in_q == $past(r.cap_q))
    else $error("second stage did not take the captured data");

endmodule

// *** dv/icco_pad_model.sv ***
// icco_pad_model.sv: pad, board pull-up and shared clock source beside the io cell
`timescale 1ns/1ps

module icco_pad_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic pad_out_in,
  input wire logic pad_oe_in,
  input wire logic ext_drive_in,
  input wire logic ext_level_in,
  output logic pad_in_out,
  output logic out_clk_out,
  output logic in_clk_out
);
  logic src_r = 1'b0;
  logic [2:0] cnt_r = 3'h0;

  // ****************************************************************
  // clock source
  // ****************************************************************
  // eight clk cycles per level, slow enough for the cell synchronisers
  always @(posedge clk_in) begin
    if (run_in) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) src_r <= ~src_r;
    end
  end

  // both stage clocks come from one source, so no pad-to-pad skew
  assign out_clk_out = src_r;
  assign in_clk_out = src_r;

  // ****************************************************************
  // pad wire
  // ****************************************************************
  // released line is pulled high, as an open-drain net needs
  assign pad_in_out = pad_oe_in ? pad_out_in : (ext_drive_in ? ext_level_in : 1'b1);
endmodule

// *** dv/testbench.sv ***
// testbench.sv: self-checking bench of the io cell over apb and pad pins
`timescale 1ns/1ps
`include "icco_params.svh"

module testbench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic pready_out, pslverr_out, pad_out, pad_oe_out, in_data_out, pad_in;
  logic [31:0] prdata_out;
  logic out_clk, in_clk, gfloat = 1'b0, extest = 1'b0;
  logic run = 1'b0, ext_drive = 1'b0, ext_level = 1'b0, v;
  logic [31:0] exp_q[$], msk_q[$];
  logic err_q[$];
  int n_fail = 0, total_checks = 0, cycles = 0;

  icco_cell i_icco_cell (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .out_clk_in(out_clk), .in_clk_in(in_clk), .global_float_in(gfloat),
    .extest_in(extest), .in_data_out(in_data_out));

  icco_pad_model i_icco_pad_model (.clk_in(clk_in), .run_in(run), .pad_out_in(pad_out),
    .pad_oe_in(pad_oe_out), .ext_drive_in(ext_drive), .ext_level_in(ext_level),
    .pad_in_out(pad_in), .out_clk_out(out_clk), .in_clk_out(in_clk));

  // ****************************************************************
  // clock, timeout, reporting
  // ****************************************************************
  always #5 clk_in = ~clk_in;

  // a hung handshake would otherwise stall the run for ever
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_apb(input logic [31:0] e, input logic [31:0] m, input logic ee);
    total_checks++;
    if (((prdata_out & m) !== (e & m)) || (pslverr_out !== ee)) begin
      n_fail++;
      $display("wrong value prdata/pslverr expected %h/%b seen %h/%b", e & m, ee,
               prdata_out & m, pslverr_out);
    end
  endtask

  task automatic cmp_bit(input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value in_data_out expected %b seen %b", e, s);
    end
  endtask

  // ****************************************************************
  // apb master and scoreboard
  // ****************************************************************
  // every transfer leaves a note; the monitor pops it at the completion edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic ee);
    exp_q.push_back(d);
    msk_q.push_back(wr ? 32'h0 : m);
    err_q.push_back(ee);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge clk_in) begin
    if (pready_out === 1'b1 && psel && penable && exp_q.size() > 0) begin
      cmp_apb(exp_q.pop_front(), msk_q.pop_front(), err_q.pop_front());
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic stat(input logic [31:0] e, input logic [31:0] m);
    repeat (40) @(posedge clk_in);
    apb(1'b0, `ICCO_STAT_ADDR, e, m, 1'b0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    v = 1'($urandom(56));
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    run <= 1'b1;
    // reset values: registered output, clear value, ce high, float low
    apb(1'b0, `ICCO_CFG_ADDR, 32'h004, 32'h7ff, 1'b0);
    apb(1'b0, `ICCO_OCTL_ADDR, 32'h002, 32'h00f, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 12'h00c, 32'h0, 32'h0, 1'b1);
    stat(32'h10, 32'h1c);
    // ce low holds the output flop across clock edges
    wr(`ICCO_OCTL_ADDR, 32'h1);
    stat(32'h00, 32'h04);
    wr(`ICCO_OCTL_ADDR, 32'h3);
    stat(32'h0c, 32'h0c);
    // direct inverted path
    wr(`ICCO_CFG_ADDR, 32'h008);
    stat(32'h00, 32'h08);
    wr(`ICCO_OCTL_ADDR, 32'h2);
    stat(32'h08, 32'h08);
    // float high wins over data and ce, then its polarity flips
    wr(`ICCO_OCTL_ADDR, 32'h7);
    stat(32'h00, 32'h10);
    wr(`ICCO_CFG_ADDR, 32'h00a);
    stat(32'h10, 32'h10);
    wr(`ICCO_OCTL_ADDR, 32'h2);
    stat(32'h00, 32'h10);
    // set value loaded by a set/reset pulse in the write that drops ce, then held
    wr(`ICCO_CFG_ADDR, 32'h005);
    wr(`ICCO_OCTL_ADDR, 32'h8);
    stat(32'h04, 32'h04);
    apb(1'b0, `ICCO_OCTL_ADDR, 32'h0, 32'h00f, 1'b0);
    // reset in mid-run clears the set flop and restores the defaults
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    stat(32'h00, 32'h04);
    apb(1'b0, `ICCO_CFG_ADDR, 32'h004, 32'h7ff, 1'b0);
    // byte lanes: each strobe guards its own part of the config word
    pstrb <= 4'h1;
    wr(`ICCO_CFG_ADDR, 32'h70c);
    apb(1'b0, `ICCO_CFG_ADDR, 32'h00c, 32'h7ff, 1'b0);
    pstrb <= 4'h2;
    wr(`ICCO_CFG_ADDR, 32'h7f3);
    apb(1'b0, `ICCO_CFG_ADDR, 32'h70c, 32'h7ff, 1'b0);
    pstrb <= 4'hf;
    // global float and its boundary-scan exception
    wr(`ICCO_CFG_ADDR, 32'h004);
    wr(`ICCO_OCTL_ADDR, 32'h2);
    gfloat <= 1'b1;
    stat(32'h00, 32'h10);
    extest <= 1'b1;
    stat(32'h10, 32'h10);
    gfloat <= 1'b0;
    extest <= 1'b0;
    // open drain: data low, float carries the signal, pull-up gives the high
    wr(`ICCO_CFG_ADDR, 32'h000);
    wr(`ICCO_OCTL_ADDR, 32'h6);
    stat(32'h20, 32'h30);
    wr(`ICCO_OCTL_ADDR, 32'h2);
    stat(32'h10, 32'h30);
    // input arrangements, clock inversions and delay taps with external drive;
    // the last few passes leave fast capture off so the plain path runs too
    wr(`ICCO_OCTL_ADDR, 32'h6);
    ext_drive <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      v = 1'($urandom());
      ext_level <= v;
      wr(`ICCO_CFG_ADDR, {21'h0, !(i[4] && i[2]), i[0], i[1], i[2], i[4:3], (i >= 8), 4'h0});
      repeat (80) @(posedge clk_in);
      cmp_bit(v, in_data_out);
    end
    finish_test();
  end
endmodule
